// *** logic/rqual_pkg.sv ***
`default_nettype none
package rqual_pkg;
    // ------------------------------------------------------------
    // register indices (printed offsets are not word aligned)
    // ------------------------------------------------------------
    localparam logic [15:0] IDX_HYST = 16'h046F;
    localparam logic [15:0] IDX_VAL_LO = 16'h0470;
    localparam logic [15:0] IDX_VAL_MID = 16'h0471;
    localparam logic [15:0] IDX_VAL_HI = 16'h0472;
    localparam logic [15:0] IDX_JIT_LO = 16'h0473;
    localparam logic [15:0] IDX_JIT_HI = 16'h0474;
    localparam logic [15:0] IDX_STATUS = 16'h0478;
    localparam logic [15:0] IDX_EVENT = 16'h0479;
    localparam logic [15:0] IDX_MASK = 16'h047A;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [2:0] RST_HYST = 3'h3;
    localparam logic [19:0] RST_VAL = 20'h0000A;
    localparam logic [15:0] RST_JIT = 16'h0000;
    localparam logic [2:0] RST_MASK = 3'h0;
    // ------------------------------------------------------------
    // event bit positions
    // ------------------------------------------------------------
    localparam int EV_VALID = 0;
    localparam int EV_LOST = 1;
    localparam int EV_JIT = 2;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 50_000_000;
    localparam int TICK_MS = 1;
    localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
    localparam logic [2:0] BUS_WAIT = 3'h1;

    typedef enum logic [1:0] {RQ_IDLE, RQ_WAIT, RQ_DONE} rqual_bus_t;

    typedef struct packed {
        logic [2:0] hyst;
        logic [19:0] vtime;
        logic [15:0] jlim;
    } rqual_cfg_t;

    typedef struct packed {
        logic valid;
        logic in_tol;
        logic jit;
    } rqual_stat_t;
endpackage : rqual_pkg
`default_nettype wire

// *** logic/rqual_top.sv ***
// What this block does
// - the fault decision uses a 3-bit selectable hysteresis band.
// - band codes give 0, 1/32, 1/16, 1/8, 1/4, 1/2, 3/4, 7/8 of the limit.
// - valid rises after the reference stays in tolerance for vtime ms.
// - excess jitter is flagged when rms jitter exceeds the 16-bit limit.
// - a jitter limit of zero disables excess-jitter detection.
// - the reference is faulted when its error exceeds the 24-bit ppb limit.
// - frequency error is taken against the 60-bit nominal period in as.
`timescale 1ns/100ps
`default_nettype none
module rqual_top #(
    parameter int TICK_CYCLES = rqual_pkg::TICK_CYC
) (
    input wire logic CORE_CLK_I,          // system clock 50 MHz
    input wire logic RESET_N_I,           // async reset, active low
    input wire logic [15:0] AVS_ADDRESS_I, // word index
    input wire logic AVS_READ_I,          // read request
    input wire logic AVS_WRITE_I,         // write request
    input wire logic [31:0] AVS_WRITEDATA_I, // write data
    input wire logic [3:0] AVS_BYTEENABLE_I, // byte lanes
    output logic [31:0] AVS_READDATA_O,   // read data
    output logic AVS_WAITREQUEST_O,       // wait request
    input wire logic [23:0] OFFSET_LIMIT_I, // frequency_offset_limit, ppb
    input wire logic [59:0] NOMINAL_PERIOD_I, // nominal_input_period, as
    input wire logic [59:0] MEAS_PERIOD_I, // measured reference period, as
    input wire logic MEAS_STROBE_I,       // new period measurement
    input wire logic [15:0] RMS_JITTER_I, // measured rms jitter, ns
    output logic REF_VALID_O,             // reference qualified
    output logic REF_FAULT_O,             // frequency out of tolerance
    output logic EXCESS_JITTER_O,         // jitter above limit
    output logic IRQ_O                    // level interrupt
);
    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    rqual_pkg::rqual_cfg_t cfg_q;
    rqual_pkg::rqual_stat_t stat_q;
    rqual_pkg::rqual_bus_t bus_q;
    logic [2:0] ev_q, mask_q, ev_set, ev_clr;
    logic [2:0] wcnt_q;
    logic rd_ev_clr;
    logic [7:0] rdata_d;
    wire logic req = AVS_READ_I | AVS_WRITE_I;
    wire logic hit = (bus_q == rqual_pkg::RQ_DONE);
    wire logic wr_go = hit & AVS_WRITE_I & AVS_BYTEENABLE_I[0];
    assign rd_ev_clr = hit & AVS_READ_I
        & (AVS_ADDRESS_I == rqual_pkg::IDX_EVENT);
    // clear only what the read returned, so an event landing mid-read stays
    assign ev_clr = rd_ev_clr ? AVS_READDATA_O[2:0] : 3'h0;

    // fixed short wait so the master always sees waitrequest high first
    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            bus_q <= rqual_pkg::RQ_IDLE;
            wcnt_q <= 3'h0;
            AVS_WAITREQUEST_O <= 1'b1;
        end else begin
            case (bus_q)
                rqual_pkg::RQ_IDLE: begin
                    AVS_WAITREQUEST_O <= 1'b1;
                    if (req) begin
                        bus_q <= rqual_pkg::RQ_WAIT;
                        wcnt_q <= rqual_pkg::BUS_WAIT;
                    end
                end
                rqual_pkg::RQ_WAIT: begin
                    if (wcnt_q == 3'h1) begin
                        bus_q <= rqual_pkg::RQ_DONE;
                        AVS_WAITREQUEST_O <= 1'b0;
                    end
                    wcnt_q <= wcnt_q - 3'h1;
                end
                rqual_pkg::RQ_DONE: begin
                    bus_q <= rqual_pkg::RQ_IDLE;
                    AVS_WAITREQUEST_O <= 1'b1;
                end
                default: begin
                    bus_q <= rqual_pkg::RQ_IDLE;
                    AVS_WAITREQUEST_O <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            cfg_q.hyst <= rqual_pkg::RST_HYST;
            cfg_q.vtime <= rqual_pkg::RST_VAL;
            cfg_q.jlim <= rqual_pkg::RST_JIT;
            mask_q <= rqual_pkg::RST_MASK;
        end else if (wr_go) begin
            case (AVS_ADDRESS_I)
                rqual_pkg::IDX_HYST: cfg_q.hyst <= AVS_WRITEDATA_I[2:0];
                rqual_pkg::IDX_VAL_LO: begin
                    cfg_q.vtime[7:0] <= AVS_WRITEDATA_I[7:0];
                end
                rqual_pkg::IDX_VAL_MID: begin
                    cfg_q.vtime[15:8] <= AVS_WRITEDATA_I[7:0];
                end
                rqual_pkg::IDX_VAL_HI: begin
                    cfg_q.vtime[19:16] <= AVS_WRITEDATA_I[3:0];
                end
                rqual_pkg::IDX_JIT_LO: begin
                    cfg_q.jlim[7:0] <= AVS_WRITEDATA_I[7:0];
                end
                rqual_pkg::IDX_JIT_HI: begin
                    cfg_q.jlim[15:8] <= AVS_WRITEDATA_I[7:0];
                end
                rqual_pkg::IDX_MASK: mask_q <= AVS_WRITEDATA_I[2:0];
                default: ;
            endcase
        end
    end

    always_comb begin
        case (AVS_ADDRESS_I)
            rqual_pkg::IDX_HYST: rdata_d = {5'h00, cfg_q.hyst};
            rqual_pkg::IDX_VAL_LO: rdata_d = cfg_q.vtime[7:0];
            rqual_pkg::IDX_VAL_MID: rdata_d = cfg_q.vtime[15:8];
            rqual_pkg::IDX_VAL_HI: rdata_d = {4'h0, cfg_q.vtime[19:16]};
            rqual_pkg::IDX_JIT_LO: rdata_d = cfg_q.jlim[7:0];
            rqual_pkg::IDX_JIT_HI: rdata_d = cfg_q.jlim[15:8];
            rqual_pkg::IDX_STATUS: begin
                rdata_d = {5'h00, stat_q.jit, stat_q.in_tol, stat_q.valid};
            end
            rqual_pkg::IDX_EVENT: rdata_d = {5'h00, ev_q};
            rqual_pkg::IDX_MASK: rdata_d = {5'h00, mask_q};
            default: rdata_d = 8'h00;
        endcase
    end

    // read data updated while waiting so it stands at the answering edge
    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            AVS_READDATA_O <= 32'h00000000;
        end else if (bus_q == rqual_pkg::RQ_WAIT && AVS_READ_I) begin
            AVS_READDATA_O <= {24'h000000, rdata_d};
        end
    end

    // ------------------------------------------------------------
    // frequency monitor with hysteresis
    // ------------------------------------------------------------
    logic [59:0] err_q;
    logic [83:0] lhs_q;
    logic [83:0] lim_full, band, lim_hi, lim_lo;
    logic cmp_q, cmp_dly_q, in_tol_q;
    wire logic [83:0] nom_w = {24'h000000, NOMINAL_PERIOD_I};
    wire logic [83:0] lim_w = nom_w * {60'h0, OFFSET_LIMIT_I};

    always_comb begin
        lim_full = lim_w;
        case (cfg_q.hyst)
            3'h0: band = 84'h0;
            3'h1: band = lim_full >> 5;
            3'h2: band = lim_full >> 4;
            3'h3: band = lim_full >> 3;
            3'h4: band = lim_full >> 2;
            3'h5: band = lim_full >> 1;
            3'h6: band = (lim_full >> 1) + (lim_full >> 2);
            3'h7: band = lim_full - (lim_full >> 3);
            default: band = 84'h0;
        endcase
        lim_hi = lim_full;
        lim_lo = lim_full - band;
    end

    // |meas - nominal| * 1e9 compared with nominal * limit
    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            err_q <= 60'h0;
            lhs_q <= 84'h0;
            cmp_q <= 1'b0;
            cmp_dly_q <= 1'b0;
        end else begin
            cmp_q <= MEAS_STROBE_I;
            // decide only once the product of the new error has settled
            cmp_dly_q <= cmp_q;
            if (MEAS_STROBE_I) begin
                err_q <= (MEAS_PERIOD_I > NOMINAL_PERIOD_I)
                    ? MEAS_PERIOD_I - NOMINAL_PERIOD_I
                    : NOMINAL_PERIOD_I - MEAS_PERIOD_I;
            end
            lhs_q <= 84'({24'h000000, err_q} * 84'd1000000000);
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            in_tol_q <= 1'b0;
        end else if (cmp_dly_q) begin
            if (in_tol_q && lhs_q > lim_hi) begin
                in_tol_q <= 1'b0;
            end else if (!in_tol_q && lhs_q <= lim_lo) begin
                in_tol_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // millisecond tick and validation timer
    // ------------------------------------------------------------
    logic [31:0] tick_cnt_q;
    logic tick_q;
    logic [19:0] ms_q;
    logic valid_q, jit_q;

    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            tick_cnt_q <= 32'h0;
            tick_q <= 1'b0;
        end else if (tick_cnt_q == 32'(TICK_CYCLES - 1)) begin
            tick_cnt_q <= 32'h0;
            tick_q <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h1;
            tick_q <= 1'b0;
        end
    end

    // prohibited settings are not trapped; they just give odd timing
    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            ms_q <= 20'h0;
            valid_q <= 1'b0;
        end else if (!in_tol_q) begin
            ms_q <= 20'h0;
            valid_q <= 1'b0;
        end else if (!valid_q && tick_q) begin
            if (ms_q + 20'h1 >= cfg_q.vtime) begin
                valid_q <= 1'b1;
            end
            ms_q <= ms_q + 20'h1;
        end
    end

    // ------------------------------------------------------------
    // jitter check
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            jit_q <= 1'b0;
        end else begin
            jit_q <= (cfg_q.jlim != 16'h0)
                && (RMS_JITTER_I > cfg_q.jlim);
        end
    end

    // ------------------------------------------------------------
    // status, events and interrupt
    // ------------------------------------------------------------
    always_comb begin
        ev_set = 3'h0;
        ev_set[rqual_pkg::EV_VALID] = valid_q & ~stat_q.valid;
        ev_set[rqual_pkg::EV_LOST] = ~valid_q & stat_q.valid;
        ev_set[rqual_pkg::EV_JIT] = jit_q & ~stat_q.jit;
    end

    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            stat_q <= '0;
            ev_q <= 3'h0;
            IRQ_O <= 1'b0;
            REF_VALID_O <= 1'b0;
            REF_FAULT_O <= 1'b1;
            EXCESS_JITTER_O <= 1'b0;
        end else begin
            stat_q.valid <= valid_q;
            stat_q.in_tol <= in_tol_q;
            stat_q.jit <= jit_q;
            // set wins over read-clear
            ev_q <= (ev_q & ~ev_clr) | ev_set;
            IRQ_O <= |(((ev_q & ~ev_clr) | ev_set) & mask_q);
            REF_VALID_O <= valid_q;
            REF_FAULT_O <= ~in_tol_q;
            EXCESS_JITTER_O <= jit_q;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence ms_tick_s;
        tick_q;
    endsequence

    jitter_zero_off_a: assert property (@(posedge CORE_CLK_I)
        disable iff (!RESET_N_I)
        (cfg_q.jlim == 16'h0) |=> !jit_q)
        else $error("jitter flagged with zero limit");
    jitter_over_a: assert property (@(posedge CORE_CLK_I)
        disable iff (!RESET_N_I)
        (cfg_q.jlim != 16'h0 && RMS_JITTER_I > cfg_q.jlim) |=> jit_q)
        else $error("jitter over limit not flagged");
    valid_needs_tol_a: assert property (@(posedge CORE_CLK_I)
        disable iff (!RESET_N_I)
        valid_q |-> $past(in_tol_q))
        else $error("valid without tolerance");
    restart_lost_a: assert property (@(posedge CORE_CLK_I)
        disable iff (!RESET_N_I)
        $fell(in_tol_q) |=> (ms_q == 20'h0 && !valid_q))
        else $error("countdown not restarted");
    valid_rise_a: assert property (@(posedge CORE_CLK_I)
        disable iff (!RESET_N_I)
        $rose(valid_q) |-> ($past(tick_q) && ms_q >= cfg_q.vtime))
        else $error("valid early");
    fault_over_a: assert property (@(posedge CORE_CLK_I)
        disable iff (!RESET_N_I)
        (cmp_dly_q && in_tol_q && lhs_q > lim_hi) |=> !in_tol_q)
        else $error("fault not declared");
    hyst_hold_a: assert property (@(posedge CORE_CLK_I)
        disable iff (!RESET_N_I)
        (cmp_dly_q && !in_tol_q && lhs_q > lim_lo) |=> !in_tol_q)
        else $error("recovered inside band");
    hyst_zero_a: assert property (@(posedge CORE_CLK_I)
        disable iff (!RESET_N_I)
        (cmp_dly_q && !in_tol_q && cfg_q.hyst == 3'h0 && lhs_q <= lim_w)
        |=> in_tol_q)
        else $error("no recovery at limit without band");
    tick_period_a: assert property (@(posedge CORE_CLK_I)
        disable iff (!RESET_N_I)
        ms_tick_s |=> !tick_q)
        else $error("tick too frequent");
    irq_level_a: assert property (@(posedge CORE_CLK_I)
        disable iff (!RESET_N_I)
        ((ev_set & mask_q) != 3'h0) |=> IRQ_O)
        else $error("irq missing");
endmodule : rqual_top
`default_nettype wire

// *** test/rqual_ref_src.sv ***
`timescale 1ns/100ps
`default_nettype none
module rqual_ref_src (
    input wire logic clk_i, // system clock
    input wire logic rst_n_i, // async reset, active low
    input wire logic [59:0] nominal_i, // nominal period, as
    input wire logic [59:0] err_i, // period error to apply, as
    input wire logic [15:0] jit_i, // rms jitter to report, ns
    output logic [59:0] period_o, // measured period
    output logic strobe_o, // one-cycle measurement pulse
    output logic [15:0] jitter_o // rms jitter, ns
);
    logic [2:0] cnt_q;
    // the period means something only with the strobe; garbage between
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= 3'h0;
            strobe_o <= 1'b0;
            period_o <= 60'h0;
        end else begin
            cnt_q <= cnt_q + 3'h1;
            strobe_o <= (cnt_q == 3'h7);
            period_o <= (cnt_q == 3'h7) ? nominal_i + err_i : ~period_o;
        end
    end
    assign jitter_o = jit_i;
endmodule : rqual_ref_src
`default_nettype wire

// *** test/tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb;
    localparam int TICKS = 10;
    localparam logic [59:0] NOM = 60'hE8D4A51000; // 1 MHz reference
    localparam logic [59:0] THR = 60'h1E84800; // trip error for 32000 ppb
    logic clk, rst_n, rd, wr, strb, valid, fault, xjit, irq, wreq;
    logic [3:0] be;
    logic [15:0] addr, jit, rjit, lim;
    logic [31:0] wdata, rdata, q;
    logic [59:0] err, mper;
    integer seed, n_fail, checks, i, n;

    rqual_top #(.TICK_CYCLES(TICKS)) u_rqual_top (
        .CORE_CLK_I(clk), .RESET_N_I(rst_n), .AVS_ADDRESS_I(addr),
        .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata),
        .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdata),
        .AVS_WAITREQUEST_O(wreq), .OFFSET_LIMIT_I(24'h007D00),
        .NOMINAL_PERIOD_I(NOM), .MEAS_PERIOD_I(mper), .MEAS_STROBE_I(strb),
        .RMS_JITTER_I(rjit), .REF_VALID_O(valid), .REF_FAULT_O(fault),
        .EXCESS_JITTER_O(xjit), .IRQ_O(irq));

    rqual_ref_src u_rqual_ref_src (.clk_i(clk), .rst_n_i(rst_n),
        .nominal_i(NOM), .err_i(err), .jit_i(jit), .period_o(mper),
        .strobe_o(strb), .jitter_o(rjit));

    // --------
    // helpers
    // --------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string m);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask : chk

    // request held until waitrequest is sampled low, then dropped
    task automatic bus(input logic w, input logic [15:0] a,
                       input logic [7:0] d);
        integer k;
        @(posedge clk);
        addr <= a;
        rd <= !w;
        wr <= w;
        wdata <= {24'h0, d};
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (wreq !== 1'b0 && k < 50);
        if (k >= 50) begin
            chk(32'h1, 32'h0, "bus hang");
            complete_run();
        end
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus

    task automatic rd_chk(input logic [15:0] a, input logic [7:0] e,
                          input string m);
        bus(1'b0, a, 8'h00);
        chk(q, {24'h0, e}, m);
    endtask : rd_chk

    task automatic hold(input logic [59:0] e, input int c);
        err <= e;
        repeat (c) @(posedge clk);
    endtask : hold

    function automatic logic [59:0] band(input logic [2:0] c);
        logic [59:0] off;
        case (c)
            3'h0: off = 60'h0;
            3'h6: off = THR - (THR >> 2);
            3'h7: off = THR - (THR >> 3);
            default: off = THR >> (3'h6 - c);
        endcase
        band = THR - off;
    endfunction : band

    task automatic complete_run;
        $display("totals: %0d checks, %0d mismatches", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // whole run needs well under 4000 cycles
    initial begin
        repeat (30000) @(posedge clk);
        n_fail++;
        complete_run();
    end

    initial begin
        seed = 32'hF3B3;
        n_fail = 0;
        checks = 0;
        rst_n = 1'b0;
        rd = 1'b0;
        wr = 1'b0;
        be = 4'hF;
        addr = 16'h0000;
        wdata = 32'h0;
        err = 60'h0;
        jit = 16'h0000;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk(fault, 32'h1, "fault after reset");
        rd_chk(rqual_pkg::IDX_HYST, 8'h03, "hyst reset");
        rd_chk(rqual_pkg::IDX_VAL_LO, 8'h0A, "vtime lo reset");
        rd_chk(rqual_pkg::IDX_VAL_MID, 8'h00, "vtime mid reset");
        rd_chk(rqual_pkg::IDX_VAL_HI, 8'h00, "vtime hi reset");
        rd_chk(rqual_pkg::IDX_JIT_LO, 8'h00, "jit lo reset");
        rd_chk(rqual_pkg::IDX_JIT_HI, 8'h00, "jit hi reset");
        rd_chk(rqual_pkg::IDX_MASK, 8'h00, "mask reset");
        bus(1'b1, rqual_pkg::IDX_HYST, 8'hFF);
        rd_chk(rqual_pkg::IDX_HYST, 8'h07, "hyst reserved bits");
        bus(1'b1, rqual_pkg::IDX_VAL_HI, 8'hFF);
        rd_chk(rqual_pkg::IDX_VAL_HI, 8'h0F, "vtime reserved bits");
        bus(1'b1, rqual_pkg::IDX_VAL_HI, 8'h00);
        be <= 4'hE;
        bus(1'b1, rqual_pkg::IDX_VAL_LO, 8'h55);
        be <= 4'hF;
        rd_chk(rqual_pkg::IDX_VAL_LO, 8'h0A, "lane 0 off ignored");
        bus(1'b1, 16'h0475, 8'hA5);
        rd_chk(16'h0475, 8'h00, "unmapped reads zero");
        bus(1'b1, rqual_pkg::IDX_HYST, 8'h03);
        $display("test registers done");

        bus(1'b1, rqual_pkg::IDX_VAL_LO, 8'h04);
        hold(THR << 1, 24);
        bus(1'b0, rqual_pkg::IDX_EVENT, 8'h00);
        hold(60'h0, 24);
        hold(THR << 1, 24);
        hold(60'h0, 24);
        chk(valid, 32'h0, "countdown not restarted");
        n = 0;
        while (valid !== 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
        end
        chk(valid, 32'h1, "valid never rose");
        chk(irq, 32'h0, "masked event raised irq");
        rd_chk(rqual_pkg::IDX_EVENT, 8'h01, "valid rose event");
        rd_chk(rqual_pkg::IDX_STATUS, 8'h03, "status valid");
        bus(1'b1, rqual_pkg::IDX_MASK, 8'h03);
        hold(THR << 1, 24);
        chk(valid, 32'h0, "valid kept out of tolerance");
        chk(irq, 32'h1, "unmasked event irq");
        rd_chk(rqual_pkg::IDX_EVENT, 8'h02, "valid fell event");
        repeat (2) @(posedge clk);
        chk(irq, 32'h0, "irq after clear");
        $display("test validation done");

        for (i = 0; i < 8; i++) begin
            bus(1'b1, rqual_pkg::IDX_HYST, i[7:0]);
            hold(THR + 60'h3E8, 24);
            chk(fault, 32'h1, "over limit not faulted");
            hold(band(i[2:0]) + 60'h3E8, 24);
            chk(fault, 32'h1, "left fault inside band");
            hold(band(i[2:0]), 24);
            chk(fault, 32'h0, "no recovery at band edge");
        end
        $display("test hysteresis done");

        for (i = 0; i < 8; i++) begin
            lim = (i == 0) ? 16'h0001 : (16'($random(seed)) & 16'h7FFF);
            lim = lim | 16'h0001;
            bus(1'b1, rqual_pkg::IDX_JIT_LO, 8'h00);
            bus(1'b1, rqual_pkg::IDX_JIT_HI, 8'h00);
            jit <= 16'($random(seed));
            repeat (4) @(posedge clk);
            chk(xjit, 32'h0, "jitter flagged with zero limit");
            bus(1'b1, rqual_pkg::IDX_JIT_LO, lim[7:0]);
            bus(1'b1, rqual_pkg::IDX_JIT_HI, lim[15:8]);
            jit <= lim;
            repeat (4) @(posedge clk);
            chk(xjit, 32'h0, "jitter at limit flagged");
            jit <= lim + 16'h0001;
            repeat (4) @(posedge clk);
            chk(xjit, 32'h1, "jitter over limit missed");
        end
        $display("test jitter done");
        complete_run();
    end
endmodule : tb
`default_nettype wire
